// >>> verif/ata_task_file_registers_tb.sv
`timescale 1ns/10ps
module ata_task_file_registers_tb;
   import ttf_pkg::*;
   logic                   clk, rst, tf_wr, tf_rd, buf_pop, buf_push;
   logic                   dev_ready, xfer_req, cmd_done, cmd_fail;
   logic                   cmd_start, lba_mode, sector_end, q_issue, q_done;
   logic [2:0]             tf_addr;
   logic [4:0]             cause, t;
   logic [7:0]             cmd_code, cmd_feature, cnt;
   logic [15:0]            tf_wdata, tf_rdata, buf_rd_data, buf_wdata, rv;
   logic [27:0]            start_addr, a;
   logic [SECT_W-1:0]      xfer_sectors;
   logic [TAG_W-1:0]       q_tag, q_done_tag;
   logic [QUEUE_DEPTH-1:0] q_out, q_exp;
   int                     n_fail, checked, cycles, n_pop;
   localparam logic [7:0]  RST_TAB [0:6] = '{BYTE_ZERO, BYTE_ZERO,
      SEC_COUNT_RESET, SEC_LOW_RESET, CYL_RESET, CYL_RESET, UNIT_HEAD_RESET};

   ttf_task_file u_dut (.REF_CLK(clk), .RST(rst), .TF_WR(tf_wr),
      .TF_RD(tf_rd), .TF_ADDR(tf_addr), .TF_WDATA(tf_wdata),
      .TF_RDATA(tf_rdata), .BUF_RD_DATA(buf_rd_data), .BUF_POP(buf_pop),
      .BUF_PUSH(buf_push), .BUF_WDATA(buf_wdata), .DEV_READY(dev_ready),
      .XFER_REQ(xfer_req), .CMD_DONE(cmd_done), .CMD_FAIL(cmd_fail),
      .FAIL_BAD_BLOCK(cause[4]), .FAIL_UNCORR(cause[3]),
      .FAIL_ID_MISSING(cause[2]), .FAIL_ABORT(cause[1]),
      .FAIL_GENERAL(cause[0]), .CMD_START(cmd_start), .CMD_CODE(cmd_code),
      .CMD_FEATURE(cmd_feature), .LBA_MODE(lba_mode),
      .START_ADDR(start_addr), .XFER_SECTORS(xfer_sectors),
      .SECTOR_END(sector_end), .Q_ISSUE(q_issue), .Q_DONE(q_done),
      .Q_TAG(q_tag), .Q_DONE_TAG(q_done_tag), .Q_OUTSTANDING(q_out));

   ttf_host_model u_host (.clk(clk), .wr(tf_wr), .rd(tf_rd),
      .addr(tf_addr), .wdata(tf_wdata), .rdata(tf_rdata));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic results;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string w, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", w, exp, got);
      end
   endtask

   function automatic logic [7:0] err_exp(input logic [4:0] c);
      return {c[4], c[3], 1'b0, c[2], 1'b0, c[1], 1'b0, c[0]};
   endfunction

   function automatic logic [8:0] sect_exp(input logic [7:0] n);
      return (n == BYTE_ZERO) ? FULL_COUNT : {1'b0, n};
   endfunction

   task automatic rd_chk(input string w, input logic [2:0] ad,
                         input logic [7:0] exp, input logic [7:0] m);
      u_host.get(ad, rv);
      chk(w, {24'h00_0000, exp & m}, {24'h00_0000, rv[7:0] & m});
   endtask

   task automatic start_cmd(input logic [7:0] n, input logic [7:0] op);
      u_host.put(IDX_SEC_COUNT, {8'h00, n});
      u_host.put(IDX_STAT_CMD, {8'h00, op});
      #1;
      chk("cmd_start", 32'h0000_0001, {31'h0, cmd_start});
      chk("cmd_code", {24'h00_0000, op}, {24'h00_0000, cmd_code});
      chk("xfer_sectors", sect_exp(n), xfer_sectors);
   endtask

   task automatic end_cmd(input logic fail, input logic [4:0] c);
      @(posedge clk);
      cmd_fail <= fail;
      cmd_done <= ~fail;
      cause    <= c;
      @(posedge clk);
      cmd_fail <= 1'b0;
      cmd_done <= 1'b0;
      cause    <= 5'($urandom);
      repeat (2) @(posedge clk);
   endtask

   task automatic read_sector;
      logic [15:0] w;
      n_pop = 0;
      for (int i = 0; i < WORDS_PER_SECTOR; i++) begin
         w = 16'($urandom);
         @(posedge clk);
         buf_rd_data <= w;
         u_host.get(IDX_DATA, rv);
         chk("data_word", {16'h0000, w}, {16'h0000, rv});
      end
      chk("sector_end", 32'h0000_0001, {31'h0, sector_end});
      chk("buf_pops", WORDS_PER_SECTOR, n_pop);
   endtask

   always @(posedge clk) begin
      if (buf_pop === 1'b1)
         n_pop++;
      cycles++;
      if (cycles == 30000) begin
         n_fail++;
         results();
      end
   end

   initial begin
      {rst, dev_ready} = 2'b11;
      {xfer_req, cmd_done, cmd_fail, q_issue, q_done} = '0;
      {cause, q_tag, q_done_tag, buf_rd_data, q_exp} = '0;
      {n_fail, checked, cycles, n_pop} = '0;
      void'($urandom(68));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 1; i < 7; i++)
         rd_chk("reset_value", 3'(i), RST_TAB[i], 8'hFF);
      chk("start_addr_rst", 32'h0000_0001, {4'h0, start_addr});
      // Random addresses, mode and a drive bit that must be ignored
      repeat (4) begin
         a = 28'($urandom);
         cnt = 8'($urandom);
         u_host.put_addr(a, cnt[0], cnt[1]);
         u_host.put(IDX_ERR_FEAT, {8'h00, cnt});
         #1;
         chk("cmd_feature", {24'h00_0000, cnt},
             {24'h00_0000, cmd_feature});
         chk("start_addr", {4'h0, a}, {4'h0, start_addr});
         chk("lba_mode", {31'h0, cnt[0]}, {31'h0, lba_mode});
         rd_chk("unit_head", IDX_UNIT_HEAD,
                {1'b1, cnt[0], 1'b1, cnt[1], a[27:24]}, 8'hFF);
      end
      // Every failure cause, zero count among them
      for (int k = 0; k < 7; k++) begin
         cnt = (k == 0) ? BYTE_ZERO : 8'($urandom);
         t = (k < 5) ? 5'(1 << k) : 5'($urandom | 1);
         start_cmd(cnt, 8'h20);
         end_cmd(1'b1, t);
         rd_chk("err_bits", IDX_ERR_FEAT, err_exp(t), 8'hFF);
         rd_chk("err_summary", IDX_STAT_CMD, 8'h01, 8'h01);
         rd_chk("count_left", IDX_SEC_COUNT, cnt, 8'hFF);
      end
      rd_chk("err_zero_bits", IDX_ERR_FEAT, 8'h00, 8'h2A);
      // Not ready aborts the command
      @(posedge clk);
      dev_ready <= 1'b0;
      u_host.put(IDX_STAT_CMD, 16'h0020);
      repeat (3) @(posedge clk);
      dev_ready <= 1'b1;
      rd_chk("abort_bit", IDX_ERR_FEAT, 8'h04, 8'hFF);
      rd_chk("abort_summary", IDX_STAT_CMD, 8'h01, 8'h01);
      // Two sectors, fail after the first
      start_cmd(8'h02, 8'h20);
      xfer_req <= 1'b1;
      read_sector();
      chk("sectors_left", 32'h1, {23'h0, xfer_sectors});
      end_cmd(1'b1, 5'h08);
      rd_chk("count_after_fail", IDX_SEC_COUNT, 8'h01, 8'hFF);
      // One sector, success
      start_cmd(8'h01, 8'h20);
      read_sector();
      end_cmd(1'b0, 5'h1F);
      rd_chk("count_after_done", IDX_SEC_COUNT, 8'h00, 8'hFF);
      rd_chk("no_summary", IDX_STAT_CMD, 8'h00, 8'h01);
      // Data port write to the buffer
      start_cmd(8'h01, 8'h30);
      rv = 16'($urandom);
      u_host.put(IDX_DATA, rv);
      #1;
      chk("buf_push", 32'h1, {31'h0, buf_push});
      chk("buf_wdata", {16'h0, rv}, {16'h0, buf_wdata});
      xfer_req <= 1'b0;
      end_cmd(1'b0, 5'h00);
      // Fill all 32 tags back to back, then random issue and completion
      for (int i = 0; i < QUEUE_DEPTH; i++) begin
         @(posedge clk);
         q_issue <= 1'b1;
         q_tag   <= 5'(i);
      end
      @(posedge clk);
      q_issue <= 1'b0;
      q_exp = '1;
      #1 chk("q_full", q_exp, q_out);
      repeat (40) begin
         t = 5'($urandom);
         @(posedge clk);
         if (q_exp[t]) begin
            q_done     <= 1'b1;
            q_done_tag <= t;
         end else begin
            q_issue <= 1'b1;
            q_tag   <= t;
         end
         q_exp[t] = ~q_exp[t];
         @(posedge clk);
         q_issue <= 1'b0;
         q_done  <= 1'b0;
         #1 chk("q_outstanding", q_exp, q_out);
      end
      // Issue held over two edges: the second always hits a live tag
      t = 5'($urandom);
      q_exp[t] = 1'b1;
      repeat (2) begin
         @(posedge clk);
         q_issue <= 1'b1;
         q_tag   <= t;
      end
      @(posedge clk);
      q_issue <= 1'b0;
      #1 chk("q_dup", q_exp, q_out);
      rd_chk("dup_abort", IDX_ERR_FEAT, 8'h04, 8'h04);
      rd_chk("dup_summary", IDX_STAT_CMD, 8'h01, 8'h01);
      results();
   end
endmodule

// >>> verif/ttf_host_model.sv
`timescale 1ns/10ps
module ttf_host_model
   import ttf_pkg::*;
(
   input  wire logic        clk,
   output logic             wr,
   output logic             rd,
   output logic      [2:0]  addr,
   output logic      [15:0] wdata,
   input  wire logic [15:0] rdata
);
   initial begin
      wr    = 1'b0;
      rd    = 1'b0;
      addr  = 3'h0;
      wdata = 16'h0000;
   end

   // Strobe and qualifiers hold until the sampling edge; released data
   // lines are inverted so a late sample never sees a stale word
   task automatic put(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
      wdata <= ~d;
   endtask

   task automatic get(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask

   // Address fields as one frame would carry them
   task automatic put_addr(input logic [27:0] lba,
                           input logic        blk,
                           input logic        drv);
      put(IDX_SEC_LOW, {8'h00, lba[7:0]});
      put(IDX_CYL_LOW, {8'h00, lba[15:8]});
      put(IDX_CYL_HIGH, {8'h00, lba[23:16]});
      put(IDX_UNIT_HEAD, {8'h00, 1'b1, blk, 1'b1, drv,
                          lba[27:24]});
   endtask
endmodule

// >>> verilog/ttf_err_reg.sv
`timescale 1ns/10ps
module ttf_err_reg
   import ttf_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic       set,
   input  wire logic [7:0] cause,
   output logic      [7:0] err_bits,
   output logic            err_sum
);
   logic [7:0] next_err_bits;
   logic       next_err_sum;

   // A failure landing with a new command start is kept: set wins
   always_comb begin
      next_err_bits = clear ? BYTE_ZERO : err_bits;
      next_err_sum  = clear ? 1'b0 : err_sum;
      if (set) begin
         next_err_bits = next_err_bits | (cause & ERR_VALID_MASK);
         next_err_sum  = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         err_bits <= BYTE_ZERO;
         err_sum  <= 1'b0;
      end else begin
         err_bits <= next_err_bits;
         err_sum  <= next_err_sum;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_err_zero_bits: assert property ((err_bits & ~ERR_VALID_MASK) == 8'h00)
      else $error("reserved error bits not zero");
   a_err_only_sum: assert property (err_bits != 8'h00 |-> err_sum)
      else $error("error bits set without summary");
endmodule

// >>> verilog/ttf_pkg.sv
package ttf_pkg;
   localparam int SECTOR_BYTES     = 512;
   localparam int DATA_W           = 16;
   localparam int WORDS_PER_SECTOR = SECTOR_BYTES / (DATA_W / 8);
   localparam int QUEUE_DEPTH      = 32;
   localparam int TAG_W            = 5;
   localparam int SECT_W           = 9;

   // Task-file register indices as carried in the frame fields
   localparam logic [2:0] IDX_DATA      = 3'h0;
   localparam logic [2:0] IDX_ERR_FEAT  = 3'h1;
   localparam logic [2:0] IDX_SEC_COUNT = 3'h2;
   localparam logic [2:0] IDX_SEC_LOW   = 3'h3;
   localparam logic [2:0] IDX_CYL_LOW   = 3'h4;
   localparam logic [2:0] IDX_CYL_HIGH  = 3'h5;
   localparam logic [2:0] IDX_UNIT_HEAD = 3'h6;
   localparam logic [2:0] IDX_STAT_CMD  = 3'h7;

   localparam int ERR_BAD_BLOCK  = 7;
   localparam int ERR_UNCORR     = 6;
   localparam int ERR_ID_MISSING = 4;
   localparam int ERR_ABORT      = 2;
   localparam int ERR_GENERAL    = 0;
   localparam logic [7:0] ERR_VALID_MASK = 8'hD5;

   localparam int STAT_BUSY      = 7;
   localparam int STAT_READY     = 6;
   localparam int STAT_SEEK_DONE = 4;
   localparam int STAT_DRQ       = 3;
   localparam int STAT_ERR       = 0;

   localparam int UH_LBA = 6;
   localparam int UH_DRV = 4;
   localparam logic [7:0] UH_FIXED_ONES = 8'hA0;

   localparam logic [7:0]  SEC_COUNT_RESET = 8'h01;
   localparam logic [7:0]  SEC_LOW_RESET   = 8'h01;
   localparam logic [7:0]  CYL_RESET       = 8'h00;
   localparam logic [7:0]  UNIT_HEAD_RESET = 8'hA0;
   localparam logic [7:0]  BYTE_ZERO       = 8'h00;
   localparam logic [15:0] WORD_ZERO       = 16'h0000;
   localparam logic [8:0]  FULL_COUNT      = 9'h100;

   typedef enum logic [2:0] {
      TTF_IDLE  = 3'b001,
      TTF_EXEC  = 3'b010,
      TTF_ABORT = 3'b100
   } ttf_state_t;
endpackage

// >>> verilog/ttf_sec_ctr.sv
`timescale 1ns/10ps
module ttf_sec_ctr
   import ttf_pkg::*;
#(
   parameter int WORDS = WORDS_PER_SECTOR
)(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              load,
   input  wire logic [7:0]        load_count,
   input  wire logic              word_tick,
   output logic      [SECT_W-1:0] remaining,
   output logic                   sector_tick
);
   localparam int WC_W = $clog2(WORDS);
   localparam logic [WC_W-1:0] LAST_WORD = WC_W'(WORDS - 1);

   generate
      if (WORDS < 2 || (1 << WC_W) != WORDS) begin : g_bad_words
         $error("WORDS must be a power of two of at least 2");
      end
   endgenerate

   logic [WC_W-1:0]   word_cnt;
   logic [WC_W-1:0]   next_word_cnt;
   logic [SECT_W-1:0] next_remaining;
   logic              next_sector_tick;
   logic              last;

   always_comb begin
      last             = word_tick && word_cnt == LAST_WORD;
      next_word_cnt    = word_cnt;
      next_remaining   = remaining;
      next_sector_tick = 1'b0;
      if (load) begin
         next_word_cnt  = '0;
         // A count of zero asks for a full 256 sectors
         next_remaining = (load_count == BYTE_ZERO) ? FULL_COUNT
                                                    : {1'b0, load_count};
      end else if (word_tick && remaining != '0) begin
         next_word_cnt = word_cnt + 1'b1;
         if (last) begin
            next_remaining   = remaining - 1'b1;
            next_sector_tick = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         word_cnt    <= '0;
         remaining   <= '0;
         sector_tick <= 1'b0;
      end else begin
         word_cnt    <= next_word_cnt;
         remaining   <= next_remaining;
         sector_tick <= next_sector_tick;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_zero_is_full: assert property (load && load_count == 8'h00 |=>
                                    remaining == 9'h100)
      else $error("zero count did not load 256");
   a_sector_end: assert property (word_tick && !load && remaining != 0 &&
                                  word_cnt == LAST_WORD |=>
                                  sector_tick &&
                                  remaining == $past(remaining) - 1)
      else $error("sector end not counted");
endmodule

// >>> verilog/ttf_task_file.sv
`timescale 1ns/10ps
module ttf_task_file
   import ttf_pkg::*;
(
   input  wire logic              REF_CLK,
   input  wire logic              RST,
   input  wire logic              TF_WR,
   input  wire logic              TF_RD,
   input  wire logic [2:0]        TF_ADDR,
   input  wire logic [15:0]       TF_WDATA,
   output logic      [15:0]       TF_RDATA,
   input  wire logic [15:0]       BUF_RD_DATA,
   output logic                   BUF_POP,
   output logic                   BUF_PUSH,
   output logic      [15:0]       BUF_WDATA,
   input  wire logic              DEV_READY,
   input  wire logic              XFER_REQ,
   input  wire logic              CMD_DONE,
   input  wire logic              CMD_FAIL,
   input  wire logic              FAIL_BAD_BLOCK,
   input  wire logic              FAIL_UNCORR,
   input  wire logic              FAIL_ID_MISSING,
   input  wire logic              FAIL_ABORT,
   input  wire logic              FAIL_GENERAL,
   output logic                   CMD_START,
   output logic      [7:0]        CMD_CODE,
   output logic      [7:0]        CMD_FEATURE,
   output logic                   LBA_MODE,
   output logic      [27:0]       START_ADDR,
   output logic      [SECT_W-1:0] XFER_SECTORS,
   output logic                   SECTOR_END,
   input  wire logic              Q_ISSUE,
   input  wire logic              Q_DONE,
   input  wire logic [TAG_W-1:0]  Q_TAG,
   input  wire logic [TAG_W-1:0]  Q_DONE_TAG,
   output logic [QUEUE_DEPTH-1:0] Q_OUTSTANDING
);
   ttf_state_t state;
   ttf_state_t next_state;

   logic [7:0]  sec_count;
   logic [7:0]  sec_low;
   logic [7:0]  cyl_low;
   logic [7:0]  cyl_high;
   logic [7:0]  unit_head;
   logic [7:0]  next_sec_count;
   logic [7:0]  next_sec_low;
   logic [7:0]  next_cyl_low;
   logic [7:0]  next_cyl_high;
   logic [7:0]  next_unit_head;
   logic [7:0]  next_cmd_code;
   logic [7:0]  next_cmd_feature;
   logic        next_cmd_start;
   logic [15:0] next_rdata;
   logic        next_buf_push;
   logic [15:0] next_buf_wdata;

   logic        busy;
   logic        drq;
   logic        wr_cmd;
   logic        wr_data;
   logic        rd_data;
   logic        cmd_ok;
   logic        cmd_bad;
   logic [7:0]  status;
   logic [7:0]  err_bits;
   logic        err_sum;
   logic [7:0]  err_cause;
   logic        err_set;
   logic        dup_tag;
   logic [SECT_W-1:0] remaining;

   // Frames deliver one register access at a time on this port
   always_comb begin
      busy    = state != TTF_IDLE;
      drq     = busy && XFER_REQ;
      wr_cmd  = TF_WR && TF_ADDR == IDX_STAT_CMD && !busy;
      wr_data = TF_WR && TF_ADDR == IDX_DATA && drq;
      rd_data = TF_RD && TF_ADDR == IDX_DATA && drq;
      cmd_ok  = state == TTF_EXEC && CMD_DONE && !CMD_FAIL;
      cmd_bad = (state == TTF_EXEC && CMD_FAIL) || state == TTF_ABORT;
   end

   // Status carries no index pulse and no alternate copy exists
   always_comb begin
      status                 = BYTE_ZERO;
      status[STAT_BUSY]      = busy;
      status[STAT_READY]     = DEV_READY && !busy;
      status[STAT_SEEK_DONE] = DEV_READY;
      status[STAT_DRQ]       = drq;
      status[STAT_ERR]       = err_sum;
   end

   // Host pops buffer words only while the engine requests data
   assign BUF_POP = rd_data;

   always_comb begin
      next_state = state;
      unique case (state)
         TTF_IDLE: begin
            if (wr_cmd) begin
               // A not-ready drive refuses the command at once
               next_state = DEV_READY ? TTF_EXEC : TTF_ABORT;
            end
         end
         TTF_EXEC: begin
            if (CMD_DONE || CMD_FAIL) begin
               next_state = TTF_IDLE;
            end
         end
         TTF_ABORT: begin
            next_state = TTF_IDLE;
         end
         default: begin
            next_state = TTF_IDLE;
         end
      endcase
   end

   // Address registers only take host writes while the drive is idle
   always_comb begin
      next_sec_count   = sec_count;
      next_sec_low     = sec_low;
      next_cyl_low     = cyl_low;
      next_cyl_high    = cyl_high;
      next_unit_head   = unit_head;
      next_cmd_code    = CMD_CODE;
      next_cmd_feature = CMD_FEATURE;
      next_cmd_start   = wr_cmd && DEV_READY;
      if (TF_WR && !busy) begin
         unique case (TF_ADDR)
            IDX_ERR_FEAT:  next_cmd_feature = TF_WDATA[7:0];
            IDX_SEC_COUNT: next_sec_count   = TF_WDATA[7:0];
            IDX_SEC_LOW:   next_sec_low     = TF_WDATA[7:0];
            IDX_CYL_LOW:   next_cyl_low     = TF_WDATA[7:0];
            IDX_CYL_HIGH:  next_cyl_high    = TF_WDATA[7:0];
            // Bits 7 and 5 are fixed ones; the drive select bit is kept
            // but never gates a response on a one-device channel
            IDX_UNIT_HEAD: next_unit_head   = TF_WDATA[7:0]
                                              | UH_FIXED_ONES;
            IDX_STAT_CMD:  next_cmd_code    = TF_WDATA[7:0];
            default:       next_cmd_code    = CMD_CODE;
         endcase
      end
      if (cmd_ok) begin
         next_sec_count = BYTE_ZERO;
      end else if (cmd_bad) begin
         next_sec_count = remaining[7:0];
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         state       <= TTF_IDLE;
         sec_count   <= SEC_COUNT_RESET;
         sec_low     <= SEC_LOW_RESET;
         cyl_low     <= CYL_RESET;
         cyl_high    <= CYL_RESET;
         unit_head   <= UNIT_HEAD_RESET;
         CMD_CODE    <= BYTE_ZERO;
         CMD_FEATURE <= BYTE_ZERO;
         CMD_START   <= 1'b0;
      end else begin
         state       <= next_state;
         sec_count   <= next_sec_count;
         sec_low     <= next_sec_low;
         cyl_low     <= next_cyl_low;
         cyl_high    <= next_cyl_high;
         unit_head   <= next_unit_head;
         CMD_CODE    <= next_cmd_code;
         CMD_FEATURE <= next_cmd_feature;
         CMD_START   <= next_cmd_start;
      end
   end

   // Mode bit decides how the four address bytes are read
   always_comb begin
      LBA_MODE     = unit_head[UH_LBA];
      START_ADDR   = {unit_head[3:0], cyl_high, cyl_low, sec_low};
      XFER_SECTORS = remaining;
   end

   // Read answers are registered; the data port reads zero without a data request
   always_comb begin
      next_rdata = TF_RDATA;
      if (TF_RD) begin
         unique case (TF_ADDR)
            IDX_DATA:      next_rdata = drq ? BUF_RD_DATA : WORD_ZERO;
            IDX_ERR_FEAT:  next_rdata = {BYTE_ZERO, err_bits};
            IDX_SEC_COUNT: next_rdata = {BYTE_ZERO, sec_count};
            IDX_SEC_LOW:   next_rdata = {BYTE_ZERO, sec_low};
            IDX_CYL_LOW:   next_rdata = {BYTE_ZERO, cyl_low};
            IDX_CYL_HIGH:  next_rdata = {BYTE_ZERO, cyl_high};
            IDX_UNIT_HEAD: next_rdata = {BYTE_ZERO, unit_head};
            IDX_STAT_CMD:  next_rdata = {BYTE_ZERO, status};
            default:       next_rdata = WORD_ZERO;
         endcase
      end
      next_buf_push  = wr_data;
      next_buf_wdata = wr_data ? TF_WDATA : BUF_WDATA;
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         TF_RDATA  <= WORD_ZERO;
         BUF_PUSH  <= 1'b0;
         BUF_WDATA <= WORD_ZERO;
      end else begin
         TF_RDATA  <= next_rdata;
         BUF_PUSH  <= next_buf_push;
         BUF_WDATA <= next_buf_wdata;
      end
   end

   // Duplicate queue tags are a protocol violation and abort
   assign dup_tag = Q_ISSUE && Q_OUTSTANDING[Q_TAG]
                    && !(Q_DONE && Q_DONE_TAG == Q_TAG);

   always_comb begin
      err_cause                 = BYTE_ZERO;
      err_cause[ERR_BAD_BLOCK]  = FAIL_BAD_BLOCK;
      err_cause[ERR_UNCORR]     = FAIL_UNCORR;
      err_cause[ERR_ID_MISSING] = FAIL_ID_MISSING;
      err_cause[ERR_ABORT]      = FAIL_ABORT || state == TTF_ABORT
                                  || dup_tag;
      err_cause[ERR_GENERAL]    = FAIL_GENERAL;
      if (state != TTF_EXEC || !CMD_FAIL) begin
         err_cause[ERR_BAD_BLOCK]  = 1'b0;
         err_cause[ERR_UNCORR]     = 1'b0;
         err_cause[ERR_ID_MISSING] = 1'b0;
         err_cause[ERR_GENERAL]    = 1'b0;
         err_cause[ERR_ABORT]      = state == TTF_ABORT || dup_tag;
      end
      err_set = cmd_bad || dup_tag;
   end

   // Each tag slot: issue sets, completion clears, issue wins a tie
   genvar t;
   generate
      for (t = 0; t < QUEUE_DEPTH; t++) begin : g_tag
         logic next_slot;
         always_comb begin
            next_slot = Q_OUTSTANDING[t];
            if (Q_DONE && Q_DONE_TAG == TAG_W'(t)) begin
               next_slot = 1'b0;
            end
            if (Q_ISSUE && Q_TAG == TAG_W'(t)) begin
               next_slot = 1'b1;
            end
         end
         always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
               Q_OUTSTANDING[t] <= 1'b0;
            end else begin
               Q_OUTSTANDING[t] <= next_slot;
            end
         end
      end
   endgenerate

   ttf_err_reg u_err (
      .clk      (REF_CLK),
      .rst      (RST),
      .clear    (wr_cmd),
      .set      (err_set),
      .cause    (err_cause),
      .err_bits (err_bits),
      .err_sum  (err_sum)
   );

   ttf_sec_ctr #(
      .WORDS (WORDS_PER_SECTOR)
   ) u_sec (
      .clk         (REF_CLK),
      .rst         (RST),
      .load        (wr_cmd),
      .load_count  (sec_count),
      .word_tick   (wr_data || rd_data),
      .remaining   (remaining),
      .sector_tick (SECTOR_END)
   );

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);

   sequence s_cmd_accepted;
      wr_cmd && DEV_READY;
   endsequence

   sequence s_exec_until_end;
      busy && !status[STAT_READY];
   endsequence

   a_cmd_goes_busy: assert property (s_cmd_accepted |=>
                                     (CMD_START and s_exec_until_end))
      else $error("accepted command did not start");
   a_abort_not_rdy: assert property (wr_cmd && !DEV_READY |=> ##1
                                     err_bits[ERR_ABORT] && err_sum
                                     && !busy)
      else $error("not-ready command not aborted");
   a_count_success: assert property (cmd_ok |=> sec_count == 8'h00
                                     && !busy)
      else $error("sector count not zero after success");
   a_count_failure: assert property (cmd_bad |=>
                                     sec_count == $past(remaining[7:0]))
      else $error("sector count not left at remainder");
   a_fail_sets_sum: assert property (state == TTF_EXEC && CMD_FAIL
                                     && FAIL_UNCORR |=> err_sum
                                     && err_bits[ERR_UNCORR])
      else $error("failure not reported");
   a_status_err: assert property (TF_RD && TF_ADDR == IDX_STAT_CMD |=>
                                  TF_RDATA[STAT_ERR] == $past(err_sum))
      else $error("status error bit wrong");
   a_addr_compose: assert property (TF_WR && !busy
                                    && TF_ADDR == IDX_UNIT_HEAD |=>
                                    LBA_MODE == $past(TF_WDATA[UH_LBA])
                                    && START_ADDR[27:24]
                                       == $past(TF_WDATA[3:0]))
      else $error("address composition wrong");
   a_queue_dup: assert property (dup_tag |=> err_bits[ERR_ABORT])
      else $error("duplicate tag not aborted");
   a_push_data: assert property (wr_data |=> BUF_PUSH
                                 && BUF_WDATA == $past(TF_WDATA))
      else $error("data word not pushed");
   a_uh_fixed: assert property ((unit_head & 8'hA0) == 8'hA0)
      else $error("unit/head fixed bits lost");
endmodule
